// [rcm_host_model.sv]
// Behavioural two-wire bus host: drives the clock, pulls data low
`timescale 1ns/1ps
module rcm_host_model (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl,
    output logic pull_low
);
    // Quarter of the 125 ns bus clock period
    localparam realtime QTR = 31.25;
    // Idle bus: clock parked high, data released
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end
    // One bit slot, wire sampled in the middle of the high phase
    task automatic bit_io(input logic b, output logic r);
        #(QTR);
        pull_low = ~b; // Pull low only, never drive high
        #(QTR);
        scl = 1'b1;
        #(QTR);
        r = sda_wire;
        #(QTR);
        scl = 1'b0;
    endtask
    // Start or repeated start; the 1 ns offset keeps bus edges off clk
    task automatic start_c();
        @(negedge clk);
        #1;
        pull_low = 1'b0;
        // Long wait lets a slave finish its ack before the clock rises
        #(QTR * 2);
        scl = 1'b1;
        #(QTR);
        pull_low = 1'b1;
        #(QTR);
        scl = 1'b0;
    endtask
    // Stop condition, bus left idle
    task automatic stop_c();
        #(QTR);
        pull_low = 1'b1;
        #(QTR);
        scl = 1'b1;
        #(QTR);
        pull_low = 1'b0;
        #(QTR);
    endtask
    // Byte out, most significant bit first, then the slave's ack slot
    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Byte in, then our own ack or nack
    task automatic byte_in(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~mack, r);
    endtask
endmodule

// [rcm_pkg.sv]
// Shared constants for the repeater control-source selection block
package rcm_pkg;
    // Lane and register geometry
    localparam int NLANE = 4;
    localparam int REGW = 8;
    localparam int NREG = 8;
    // Register index of lane 0 on each side
    localparam logic [7:0] REG_SIDE_A = 8'h00;
    localparam logic [7:0] REG_SIDE_B = 8'h04;
    // Lane control byte fields
    localparam int EQ_LSB = 0;
    localparam int EQ_W = 3;
    localparam int DE_LSB = 3;
    localparam int DE_W = 3;
    localparam int SW_LSB = 6;
    localparam int SW_W = 2;
    // Values applied in pin mode for fields that have no pins
    localparam logic [DE_W-1:0] PIN_DEEMPH = 3'h0;
    localparam logic [SW_W-1:0] PIN_SWING = 2'h1;
    // Value of every lane register after reset
    localparam logic [REGW-1:0] REG_RST = 8'h00;
    // Fixed upper bits of the 7-bit slave address
    localparam logic [2:0] ADDR_HI = 3'h5;
    // Bits in one byte, last bit index
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Slave sequencer states
    typedef enum logic [3:0] {
        RCM_IDLE = 4'h0,
        RCM_ADDR = 4'h1,
        RCM_ACK_A = 4'h2,
        RCM_CMD = 4'h3,
        RCM_ACK_C = 4'h4,
        RCM_WDATA = 4'h5,
        RCM_ACK_W = 4'h6,
        RCM_RDATA = 4'h7,
        RCM_RACK = 4'h8
    } rcm_state_e;
endpackage

// [rcm_smb_slave.sv]
// Two-wire management bus slave: address match, byte writes and reads
`timescale 1ns/1ps
module rcm_smb_slave (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic scl_s,
    input wire logic sda_s,
    input wire logic [3:0] addr,
    input wire logic [rcm_pkg::REGW-1:0] rd_data,
    output logic sda_oe,
    output logic wr_stb,
    output logic [7:0] ptr,
    output logic [7:0] wr_data
);
    import rcm_pkg::*;

    rcm_state_e st_r; // Sequencer state
    logic scl_d_r; // Previous clock level
    logic sda_d_r; // Previous data level
    logic [7:0] sh_r; // Receive shift register
    logic [7:0] tx_r; // Transmit shift register
    logic [2:0] cnt_r; // Bit counter
    logic [3:0] rcv_r; // Bits received in this byte
    logic scl_rise, scl_fall, start, stop;

    // Edge and framing detection on already synchronised lines
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign start = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop = scl_s && scl_d_r && !sda_d_r && sda_s;

    // Delay registers for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Byte sequencer; disabled bus sits idle and never drives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= RCM_IDLE;
            sda_oe <= 1'b0;
            wr_stb <= 1'b0;
            ptr <= 8'h00;
            wr_data <= 8'h00;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            cnt_r <= 3'h0;
            rcv_r <= 4'h0;
        end else begin
            wr_stb <= 1'b0;
            if (!enable) begin
                st_r <= RCM_IDLE;
                sda_oe <= 1'b0;
            end else if (start) begin
                // Repeated start also lands here
                st_r <= RCM_ADDR;
                sda_oe <= 1'b0;
                rcv_r <= 4'h0;
            end else if (stop) begin
                st_r <= RCM_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                // Sample on rising clock
                if (st_r == RCM_ADDR || st_r == RCM_CMD ||
                    st_r == RCM_WDATA) begin
                    sh_r <= {sh_r[6:0], sda_s};
                    rcv_r <= rcv_r + 4'h1;
                end else if (st_r == RCM_RACK) begin
                    ptr <= ptr + 8'h01; // Reads auto-increment
                    sh_r[0] <= sda_s; // Master ack, low means more
                end
            end else if (scl_fall) begin
                // Change drive only while the clock is low
                unique case (st_r)
                    RCM_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    RCM_ADDR: begin
                        if (rcv_r[3]) begin
                            // Own address only
                            if (sh_r[7:1] == {ADDR_HI, addr}) begin
                                st_r <= RCM_ACK_A;
                                sda_oe <= 1'b1;
                            end else begin
                                st_r <= RCM_IDLE;
                            end
                        end
                    end
                    RCM_ACK_A: begin
                        rcv_r <= 4'h0;
                        if (sh_r[0]) begin
                            st_r <= RCM_RDATA;
                            tx_r <= rd_data;
                            cnt_r <= 3'h0;
                            sda_oe <= ~rd_data[7]; // Pull low only
                        end else begin
                            st_r <= RCM_CMD;
                            sda_oe <= 1'b0;
                        end
                    end
                    RCM_CMD: begin
                        if (rcv_r[3]) begin
                            ptr <= sh_r;
                            st_r <= RCM_ACK_C;
                            sda_oe <= 1'b1;
                        end
                    end
                    RCM_ACK_C: begin
                        st_r <= RCM_WDATA;
                        sda_oe <= 1'b0;
                        rcv_r <= 4'h0;
                    end
                    RCM_WDATA: begin
                        if (rcv_r[3]) begin
                            wr_data <= sh_r;
                            wr_stb <= 1'b1; // Whole byte commits at once
                            st_r <= RCM_ACK_W;
                            sda_oe <= 1'b1;
                        end
                    end
                    RCM_ACK_W: begin
                        ptr <= ptr + 8'h01;
                        st_r <= RCM_WDATA;
                        sda_oe <= 1'b0;
                        rcv_r <= 4'h0;
                    end
                    RCM_RDATA: begin
                        if (cnt_r == BIT_LAST) begin
                            st_r <= RCM_RACK;
                            sda_oe <= 1'b0;
                        end else begin
                            cnt_r <= cnt_r + 3'h1;
                            tx_r <= {tx_r[6:0], 1'b0};
                            sda_oe <= ~tx_r[6];
                        end
                    end
                    RCM_RACK: begin
                        if (!sh_r[0]) begin
                            st_r <= RCM_RDATA;
                            tx_r <= rd_data;
                            cnt_r <= 3'h0;
                            sda_oe <= ~rd_data[7];
                        end else begin
                            st_r <= RCM_IDLE;
                        end
                    end
                    default: begin
                        st_r <= RCM_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Address acknowledge only after a matching address byte
    property p_addr_match;
        @(posedge clk) disable iff (!rst_n)
        (st_r == RCM_ACK_A && $past(st_r) != RCM_ACK_A)
            |-> $past(sh_r[7:1]) == {ADDR_HI, $past(addr)};
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("ack given to foreign address");

    // Drive begins only on a falling clock edge
    property p_oe_on_low;
        @(posedge clk) disable iff (!rst_n)
        // Fall is seen one edge before the drive register moves
        $rose(sda_oe) |-> !scl_s && !$past(scl_s) && $past(scl_s, 2);
    endproperty
    a_oe_on_low: assert property (p_oe_on_low)
        else $error("data drive changed while clock high");
endmodule

// [rcm_top.sv]
// Control-source selection for a four-lane repeater
// Function
// - Strap high: registers reachable over management bus
// - Strap low: bus blocked, pins control settings
// - Strap defaults low, selecting pin mode
// - Bus clock input enabled only when strap high
// - Data line open-drain pull-low, host pulls up
// - Four straps set the slave address
// - Level pins ignored in management mode
// - Pin mode: one level per side, shared by all of that side's lanes
// - Management mode: per-lane settings from registers
`timescale 1ns/1ps
module rcm_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic mgmt_bus_enable_strap,
    input wire logic [3:0] slave_addr_straps,
    input wire logic side_a_eq_level_pin0,
    input wire logic side_a_eq_level_pin1,
    input wire logic side_b_eq_level_pin0,
    input wire logic side_b_eq_level_pin1,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic smb_mode,
    output logic [rcm_pkg::NLANE*rcm_pkg::REGW-1:0] lane_ctl_a,
    output logic [rcm_pkg::NLANE*rcm_pkg::REGW-1:0] lane_ctl_b
);
    import rcm_pkg::*;

    logic [1:0] rst_sync_r; // Reset release synchroniser
    logic rst_n; // Synchronised reset
    logic [10:0] pin_s1_r; // First sync stage, read by stage two only
    logic [10:0] pin_s2_r; // Second sync stage
    logic mode_s; // Synchronised strap
    logic scl_s, sda_s;
    logic [3:0] addr_s;
    logic [1:0] eq_a_s, eq_b_s;
    logic [REGW-1:0] regs_r [0:NREG-1]; // Per-lane control bytes
    logic [NLANE*REGW-1:0] regs_a, regs_b; // Flattened register view
    logic [REGW-1:0] rd_data;
    logic [REGW-1:0] pin_byte_a, pin_byte_b;
    logic wr_stb, oe_w;
    logic [7:0] ptr, wr_data;

    // Pin-mode lane byte from a side's two level pins
    function automatic logic [REGW-1:0] pin_byte(input logic [1:0] lv);
        pin_byte = {PIN_SWING, PIN_DEEMPH, 1'b0, lv};
    endfunction

    // Async assert, clocked release of reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Two-flop sync of every pin; strap resets low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= 11'h600; // Bus lines idle high, strap low
            pin_s2_r <= 11'h600;
        end else begin
            pin_s1_r <= {scl_in, sda_in, mgmt_bus_enable_strap,
                         slave_addr_straps, side_a_eq_level_pin1,
                         side_a_eq_level_pin0, side_b_eq_level_pin1,
                         side_b_eq_level_pin0};
            pin_s2_r <= pin_s1_r;
        end
    end
    assign scl_s = pin_s2_r[10];
    assign sda_s = pin_s2_r[9];
    assign mode_s = pin_s2_r[8];
    assign addr_s = pin_s2_r[7:4];
    assign eq_a_s = pin_s2_r[3:2];
    assign eq_b_s = pin_s2_r[1:0];
    assign pin_byte_a = pin_byte(eq_a_s);
    assign pin_byte_b = pin_byte(eq_b_s);

    // Bus slave; idle and silent unless the strap is high
    rcm_smb_slave u_slave (
        .clk(clk),
        .rst_n(rst_n),
        .enable(mode_s),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .addr(addr_s),
        .rd_data(rd_data),
        .sda_oe(oe_w),
        .wr_stb(wr_stb),
        .ptr(ptr),
        .wr_data(wr_data)
    );

    // Readback; unmapped indices read zero
    assign rd_data = (ptr < 8'(NREG)) ? regs_r[ptr[2:0]] : 8'h00;

    // Lane registers, written only in management mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NREG; i++) begin
                regs_r[i] <= REG_RST;
            end
        end else if (wr_stb && mode_s && ptr < 8'(NREG)) begin
            regs_r[ptr[2:0]] <= wr_data;
        end
    end

    // Flatten register bytes per side
    genvar g;
    generate
        for (g = 0; g < NLANE; g++) begin : g_flat
            assign regs_a[g*REGW +: REGW] = regs_r[REG_SIDE_A[2:0] + g];
            assign regs_b[g*REGW +: REGW] = regs_r[REG_SIDE_B[2:0] + g];
        end
    endgenerate

    // Open drain: output level fixed low, only enable moves
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe <= oe_w && mode_s;
        end
    end

    // Source select; all lanes and the mode flag move together
    // from one sampled strap, so no mixed state is ever seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            smb_mode <= 1'b0;
            lane_ctl_a <= {NLANE{PIN_SWING, PIN_DEEMPH, 3'h0}};
            lane_ctl_b <= {NLANE{PIN_SWING, PIN_DEEMPH, 3'h0}};
        end else begin
            smb_mode <= mode_s;
            if (mode_s) begin
                lane_ctl_a <= regs_a;
                lane_ctl_b <= regs_b;
            end else begin
                lane_ctl_a <= {NLANE{pin_byte_a}};
                lane_ctl_b <= {NLANE{pin_byte_b}};
            end
        end
    end

    // Pin mode: every lane carries the side's pin level
    property p_pin_mode;
        @(posedge clk) disable iff (!rst_n)
        !mode_s |=> lane_ctl_a == {NLANE{$past(pin_byte_a)}} &&
            lane_ctl_b == {NLANE{$past(pin_byte_b)}};
    endproperty
    a_pin_mode: assert property (p_pin_mode)
        else $error("pin level not applied to all lanes");

    // Management mode: pins ignored, registers drive lanes
    property p_reg_mode;
        @(posedge clk) disable iff (!rst_n)
        mode_s |=> lane_ctl_a == $past(regs_a) &&
            lane_ctl_b == $past(regs_b);
    endproperty
    a_reg_mode: assert property (p_reg_mode)
        else $error("lane settings not from registers");

    // No drive on the data line in pin mode
    property p_no_drive;
        @(posedge clk) disable iff (!rst_n)
        !mode_s |=> !sda_oe && !sda_out;
    endproperty
    a_no_drive: assert property (p_no_drive)
        else $error("data line driven in pin mode");

    // No register write while the strap is low
    property p_no_write;
        @(posedge clk) disable iff (!rst_n)
        !mode_s ##1 !mode_s |-> !wr_stb;
    endproperty
    a_no_write: assert property (p_no_write)
        else $error("bus write with strap low");

    // Accepted write lands in the addressed register
    property p_write;
        @(posedge clk) disable iff (!rst_n)
        wr_stb && mode_s && ptr < 8'(NREG)
            |=> regs_r[$past(ptr[2:0])] == $past(wr_data);
    endproperty
    a_write: assert property (p_write)
        else $error("register write lost");

    // Pin mode after reset release for the sync latency
    property p_rst_default;
        @(posedge clk) $rose(rst_n) |-> !smb_mode [*2];
    endproperty
    a_rst_default: assert property (p_rst_default)
        else $error("not in pin mode after reset");

    // Mode flag tracks the strap with one cycle of delay
    property p_switch;
        @(posedge clk) disable iff (!rst_n)
        $changed(mode_s) |=> smb_mode == $past(mode_s) &&
            (smb_mode ? lane_ctl_a == $past(regs_a)
                      : lane_ctl_a == {NLANE{$past(pin_byte_a)}});
    endproperty
    a_switch: assert property (p_switch)
        else $error("source switch not atomic");
endmodule

// [test_repeater_control_mode_select.sv]
// Self-checking bench for the repeater control-source selection block
`timescale 1ns/1ps
module test_repeater_control_mode_select;
    import rcm_pkg::*;
    logic clk = 1'b0; // System clock
    logic nrst = 1'b0; // Active-low reset
    logic strap = 1'b0; // Mode strap, low like its pull-down
    logic [3:0] addr_straps = 4'h6; // Slave address low bits
    logic [3:0] eq_pins = 4'h0; // {b1, b0, a1, a0}
    logic scl; // Bus clock from host
    logic host_low; // Host pulling data low
    logic sda_wire; // Resolved data line
    logic sda_out;
    logic sda_oe;
    logic smb_mode;
    logic [31:0] lane_a;
    logic [31:0] lane_b;
    logic [63:0] regs = 64'h0; // Expected register image
    logic ack;
    logic [7:0] rd;
    int num_errors = 0;
    int n_tests = 0;
    // Wired-AND line with pull-up: released means high
    assign sda_wire = host_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);
    // 100 MHz clock
    always #5 clk = ~clk;
    rcm_top rcm_top_i (
        .clk(clk),
        .nrst(nrst),
        .mgmt_bus_enable_strap(strap),
        .slave_addr_straps(addr_straps),
        .side_a_eq_level_pin0(eq_pins[0]),
        .side_a_eq_level_pin1(eq_pins[1]),
        .side_b_eq_level_pin0(eq_pins[2]),
        .side_b_eq_level_pin1(eq_pins[3]),
        .scl_in(scl),
        .sda_in(sda_wire),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .smb_mode(smb_mode),
        .lane_ctl_a(lane_a),
        .lane_ctl_b(lane_b)
    );
    rcm_host_model rcm_host_model_i (
        .clk(clk),
        .sda_wire(sda_wire),
        .scl(scl),
        .pull_low(host_low)
    );
    // Lane byte in pin mode
    function automatic logic [7:0] pin_byte(input logic p1, input logic p0);
        return {PIN_SWING, PIN_DEEMPH, 1'b0, p1, p0};
    endfunction
    // All eight lanes, side B above side A, from the level pins
    function automatic logic [63:0] pin_lanes();
        return {{4{pin_byte(eq_pins[3], eq_pins[2])}},
            {4{pin_byte(eq_pins[1], eq_pins[0])}}};
    endfunction
    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // Counts, verdict, end of run
    task automatic conclude();
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One byte to the slave, ack judged against expectation
    task automatic send(input logic [7:0] b, input logic exp_ack);
        rcm_host_model_i.byte_out(b, ack);
        check(64'(ack), 64'(exp_ack));
    endtask
    // Values held during reset, strap low
    task automatic t_reset();
        wait_clk(2);
        check({lane_b, lane_a}, pin_lanes());
        check(64'(smb_mode), 64'h0);
        nrst = 1'b1;
        wait_clk(10);
    endtask
    // Every level code on both sides, lanes share it
    task automatic t_pins();
        for (int c = 0; c < 4; c++) begin
            eq_pins = {2'(3 - c), 2'(c)};
            wait_clk(8);
            check({lane_b, lane_a}, pin_lanes());
            check(64'(smb_mode), 64'h0);
        end
    endtask
    // Bus traffic ignored while the strap is low
    task automatic t_blocked();
        rcm_host_model_i.start_c();
        send({ADDR_HI, addr_straps, 1'b0}, 1'b0);
        send(REG_SIDE_A, 1'b0);
        send(8'hff, 1'b0);
        rcm_host_model_i.stop_c();
        wait_clk(6);
        check({lane_b, lane_a}, pin_lanes());
    endtask
    // Management mode writes, per-lane values, address straps
    task automatic t_mgmt();
        strap = 1'b1;
        wait_clk(10);
        check(64'(smb_mode), 64'h1);
        check({lane_b, lane_a}, regs);
        eq_pins = 4'h5;
        wait_clk(8);
        check({lane_b, lane_a}, regs);
        rcm_host_model_i.start_c();
        send({ADDR_HI, addr_straps, 1'b0}, 1'b1);
        send(REG_SIDE_A, 1'b1);
        for (int i = 0; i < NREG; i++) begin
            regs[8*i+:8] = 8'(i * 37 + 3);
            send(regs[8*i+:8], 1'b1);
        end
        // Past the last register: acked, dropped
        send(8'hff, 1'b1);
        rcm_host_model_i.stop_c();
        wait_clk(6);
        check({lane_b, lane_a}, regs);
        rcm_host_model_i.start_c();
        send({ADDR_HI, ~addr_straps, 1'b0}, 1'b0);
        rcm_host_model_i.stop_c();
        wait_clk(1); // Straps move on a falling edge only
        addr_straps = 4'h9;
        wait_clk(10);
        rcm_host_model_i.start_c();
        send({ADDR_HI, 4'h9, 1'b0}, 1'b1);
        send(REG_SIDE_B + 8'h02, 1'b1);
        regs[48+:8] = 8'h5a;
        send(8'h5a, 1'b1);
        rcm_host_model_i.stop_c();
        wait_clk(6);
        check({lane_b, lane_a}, regs);
    endtask
    // Read back three registers across a repeated start
    task automatic t_read();
        rcm_host_model_i.start_c();
        send({ADDR_HI, addr_straps, 1'b0}, 1'b1);
        send(8'h05, 1'b1);
        rcm_host_model_i.start_c();
        send({ADDR_HI, addr_straps, 1'b1}, 1'b1);
        for (int i = 0; i < 3; i++) begin
            rcm_host_model_i.byte_in(i < 2, rd);
            check(64'(rd), 64'(regs[8*(5+i)+:8]));
        end
        // Pointer now past the map: read gives zero
        rcm_host_model_i.start_c();
        send({ADDR_HI, addr_straps, 1'b1}, 1'b1);
        rcm_host_model_i.byte_in(1'b0, rd);
        check(64'(rd), 64'h0);
        rcm_host_model_i.stop_c();
        check(64'(sda_out), 64'h0);
    endtask
    // Strap flips: lanes and mode move together, registers kept
    task automatic t_switch();
        wait_clk(1); // Realign to a falling edge after bus traffic
        strap = 1'b0;
        repeat (10) begin
            @(negedge clk);
            check({lane_b, lane_a}, smb_mode ? regs : pin_lanes());
        end
        check(64'(smb_mode), 64'h0);
        check({lane_b, lane_a}, pin_lanes());
        strap = 1'b1;
        wait_clk(8);
        check({lane_b, lane_a}, regs);
    endtask
    // Main sequence; all inputs but the bus lines change on falling edges only
    initial begin
        @(negedge clk);
        t_reset();
        t_pins();
        t_blocked();
        t_mgmt();
        t_read();
        t_switch();
        conclude();
    end
    // Hang guard
    initial begin
        #900us;
        num_errors++;
        $display("mismatch at %0t: run did not finish", $time);
        conclude();
    end
endmodule
